// ### pkg/dacc_pkg.sv
// Shared constants for the dual converter conversion control
package dacc_pkg;
  // ***************************************************************
  // Register offsets (index of an 8-bit register)
  // ***************************************************************
  localparam int ADDR_W = 4;
  localparam logic [3:0] ADDR_C1_CTL0 = 4'h0;
  localparam logic [3:0] ADDR_C2_CTL0 = 4'h1;
  localparam logic [3:0] ADDR_SHARED = 4'h2;
  localparam logic [3:0] ADDR_C1_CTL2 = 4'h3;
  localparam logic [3:0] ADDR_C2_CTL2 = 4'h4;
  localparam logic [3:0] ADDR_DONE = 4'h5;
  localparam logic [3:0] ADDR_DSEN = 4'h6;
  localparam logic [3:0] ADDR_IE = 4'h7;
  localparam int RES_SEL_BIT = 3;
  localparam int RES_CONV_BIT = 2;
  localparam int RES_SET_BIT = 1;
  localparam int RES_LO_BIT = 0;
  // ***************************************************************
  // Field layouts and reset values
  // ***************************************************************
  localparam int EN_BIT = 0;
  localparam int GO_BIT = 1;
  localparam int CHS_LO = 2;
  localparam int CHS_HI = 7;
  localparam int FMT_BIT = 7;
  localparam int CLK_LO = 4;
  localparam int CLK_HI = 6;
  localparam int SYNC_BIT = 2;
  localparam int TRG_LO = 4;
  localparam int TRG_HI = 6;
  localparam logic [7:0] SHARED_KEEP = 8'h0b;
  localparam logic [7:0] CTL0_RST = 8'h00;
  localparam logic [7:0] REG_RST = 8'h00;
  // ***************************************************************
  // Conversion timing in half bit periods
  // ***************************************************************
  localparam int RES_W = 10;
  localparam logic [4:0] HALF_FIRST = 5'd2;
  localparam logic [4:0] HALF_LAST = 5'd20;
  localparam logic [4:0] HALF_END = 5'd23;
  localparam logic [9:0] SAR_INIT = 10'h200;
  localparam logic [3:0] NDEC_FULL = 4'd10;
  // ***************************************************************
  // Trigger select codes and channel codes
  // ***************************************************************
  localparam logic [2:0] TRG_NONE = 3'h0;
  localparam logic [2:0] TRG_TMR4 = 3'h2;
  localparam logic [2:0] TRG_TMR0 = 3'h3;
  localparam logic [2:0] TRG_TMR1 = 3'h4;
  localparam logic [2:0] TRG_TMR2 = 3'h5;
  localparam logic [2:0] TRG_PINR = 3'h6;
  localparam logic [2:0] TRG_PINF = 3'h7;
  localparam logic [5:0] CH_FVR = 6'h3f;
  localparam logic [5:0] CH_TEMP = 6'h3d;
  localparam logic [5:0] CH_POSITIVE_CONV_REFERENCE = 6'h3b;
  localparam logic [5:0] CH_AN2 = 6'h02;
  localparam logic [5:0] CH_C1_LO = 6'h0a;
  localparam logic [5:0] CH_C1_HI = 6'h13;
  localparam logic [5:0] CH_C2_LO = 6'h14;
  localparam logic [5:0] CH_C2_HI = 6'h1d;
  localparam logic [5:0] CH_C2_X_LO = 6'h28;
  localparam logic [5:0] CH_C2_X_HI = 6'h2d;
  typedef enum logic [1:0] {CS_IDLE, CS_WAIT, CS_CONV} dacc_state_t;
endpackage : dacc_pkg

// ### verif/dacc_afe_model.sv
// Comparator model of both converters' analog front end
`timescale 1ns/10ps
module dacc_afe_model (
  // Levels on the selected channels
  input wire logic [9:0] level1,
  input wire logic [9:0] level2,
  // Converter side
  input wire logic [19:0] sarTrial,
  input wire logic [1:0] muxConnect,
  output logic [1:0] cmpHigh
);
  // Disconnected input reads as ground
  assign cmpHigh[0] = muxConnect[0] && sarTrial[9:0] <= level1;
  assign cmpHigh[1] = muxConnect[1] && sarTrial[19:10] <= level2;
endmodule : dacc_afe_model

// ### verif/dacc_checker.sv
// Port checker for the dual converter sequencer
`timescale 1ns/10ps
module dacc_checker
  import dacc_pkg::*;
#(
  parameter int INSTR_CYCLES = 4
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Register port
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrStb,
  input wire logic regRdStb,
  input wire logic [7:0] regRdData,
  // Converter state
  input wire logic sleepMode,
  input wire logic [1:0] muxConnect,
  input wire logic [11:0] muxCode,
  input wire logic [19:0] sarTrial,
  input wire logic [1:0] convActive,
  input wire logic [1:0] doneFlag,
  input wire logic wakeReq
);
  default clocking dcb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // ***************************
  // Helper decode and counter
  // ***************************
  logic wrC1;
  logic wrC2;
  logic abort1;
  logic [7:0] actCnt_q;
  logic [7:0] actCnt_d;
  assign wrC1 = regWrStb && regAddr == ADDR_C1_CTL0;
  assign wrC2 = regWrStb && regAddr == ADDR_C2_CTL0;
  assign abort1 = wrC1 && regWrData[EN_BIT] && !regWrData[GO_BIT]
    && convActive[0];
  assign actCnt_d = !convActive[0] ? 8'h00
    : (actCnt_q == 8'hff ? actCnt_q : actCnt_q + 8'h01);
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) actCnt_q <= 8'h00;
    else actCnt_q <= actCnt_d;
  end
  property p_rdIdle;
    !$past(regRdStb) |-> regRdData == 8'h00;
  endproperty
  a_rdIdle: assert property (p_rdIdle)
    else $error("read data outside read cycle");
  property p_muxCode;
    wrC1 |=> muxCode[5:0] == $past(regWrData[CHS_HI:CHS_LO]);
  endproperty
  a_muxCode: assert property (p_muxCode)
    else $error("channel field not taken");
  property p_sarInit;
    $rose(convActive[0]) |-> sarTrial[9:0] == SAR_INIT;
  endproperty
  a_sarInit: assert property (p_sarInit)
    else $error("conversion start trial wrong");
  property p_abortStop;
    abort1 |-> ##[1:2] !convActive[0];
  endproperty
  a_abortStop: assert property (p_abortStop)
    else $error("cleared go did not stop");
  property p_abortNoFlag;
    abort1 && !doneFlag[0] |=> !doneFlag[0] [*2];
  endproperty
  a_abortNoFlag: assert property (p_abortNoFlag)
    else $error("aborted conversion set flag");
  property p_muxOff2;
    wrC2 && !regWrData[EN_BIT] |-> ##[1:2] !muxConnect[1];
  endproperty
  a_muxOff2: assert property (p_muxOff2)
    else $error("disabled converter still connected");
  property p_doneRise;
    $rose(doneFlag[0]) |-> $past(convActive[0]);
  endproperty
  a_doneRise: assert property (p_doneRise)
    else $error("flag set without conversion");
  property p_doneClr;
    $fell(doneFlag[0])
      |-> $past(regWrStb && regAddr == ADDR_DONE && !regWrData[0]);
  endproperty
  a_doneClr: assert property (p_doneClr)
    else $error("flag cleared without write");
  property p_convLen;
    $rose(doneFlag[0]) |-> actCnt_q >= 8'd20;
  endproperty
  a_convLen: assert property (p_convLen)
    else $error("conversion too short");
  property p_wake;
    wakeReq |-> $past(sleepMode) && $past(doneFlag) != 2'b00;
  endproperty
  a_wake: assert property (p_wake)
    else $error("wake without done in sleep");
  c_done: cover property ($rose(doneFlag[0]));
  c_sync: cover property (convActive == 2'b11);
  c_wake: cover property ($rose(wakeReq));
endmodule : dacc_checker

// ### verif/dacc_top_test.sv
// Self-checking bench of the dual converter sequencer
`timescale 1ns/10ps
module dacc_top_test
  import dacc_pkg::*;
;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [ADDR_W-1:0] regAddr = 4'h0;
  logic [7:0] regWrData = 8'h00;
  logic regWrStb = 1'b0;
  logic regRdStb = 1'b0;
  logic sleepMode = 1'b0;
  logic rcHalfTick = 1'b0;
  logic [1:0] rcCnt = 2'h0;
  logic tmr0Ovf = 1'b0;
  logic tmr1Ovf = 1'b0;
  logic tmr2Match = 1'b0;
  logic tmr4Match = 1'b0;
  logic extTrigPin = 1'b0;
  logic [9:0] level1 = 10'h000;
  logic [9:0] level2 = 10'h000;
  logic [7:0] regRdData;
  logic [1:0] cmpHigh, muxConnect, convActive, doneFlag;
  logic [11:0] muxCode;
  logic [19:0] sarTrial;
  logic wakeReq;
  int error_cnt = 0;
  int comparisons = 0;
  always #2 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    rcCnt <= (rcCnt == 2'h2) ? 2'h0 : rcCnt + 2'h1;
    rcHalfTick <= rcCnt == 2'h2;
  end
  dacc_top #(.INSTR_CYCLES(4)) dacc_top_inst (.clk_sys(clk_sys),
    .rst_n(rst_n), .regAddr(regAddr), .regWrData(regWrData),
    .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData),
    .sleepMode(sleepMode), .rcHalfTick(rcHalfTick), .tmr0Ovf(tmr0Ovf),
    .tmr1Ovf(tmr1Ovf), .tmr2Match(tmr2Match), .tmr4Match(tmr4Match),
    .extTrigPin(extTrigPin), .cmpHigh(cmpHigh), .muxConnect(muxConnect),
    .muxCode(muxCode), .sarTrial(sarTrial), .convActive(convActive),
    .doneFlag(doneFlag), .wakeReq(wakeReq));
  dacc_afe_model dacc_afe_model_inst (.level1(level1), .level2(level2),
    .sarTrial(sarTrial), .muxConnect(muxConnect), .cmpHigh(cmpHigh));
  // ***************************
  // Bus, wait and check tasks
  // ***************************
  task automatic end_of_test();
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : cyc
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    regWrStb <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge clk_sys);
    regWrStb <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [7:0] exp,
      input logic [7:0] m = 8'hff);
    @(posedge clk_sys);
    regRdStb <= 1'b1;
    regAddr <= a;
    @(posedge clk_sys);
    regRdStb <= 1'b0;
    #1;
    chk(regRdData & m, exp);
  endtask : rd
  task automatic waitc(input logic [1:0] m, input int n, input logic fin);
    for (int i = 0; i < n; i++) begin
      cyc(1);
      if (fin ? (doneFlag & m) == m : (convActive & m) != 2'b00) return;
    end
    error_cnt++;
    $display("CHECK FAILED %0t wait ran out", $time);
    end_of_test();
  endtask : waitc
  task automatic src(input logic [2:0] c, input logic v);
    case (c)
      TRG_TMR4: tmr4Match <= v;
      TRG_TMR0: tmr0Ovf <= v;
      TRG_TMR1: tmr1Ovf <= v;
      TRG_TMR2: tmr2Match <= v;
      default: extTrigPin <= v;
    endcase
  endtask : src
  // ***************************
  // Scenarios
  // ***************************
  task automatic t_regs();
    rd(ADDR_C1_CTL0, CTL0_RST);
    rd(ADDR_C2_CTL0, CTL0_RST);
    wr(ADDR_C1_CTL0, 8'h02);
    rd(ADDR_C1_CTL0, 8'h00);
    wr(ADDR_C1_CTL0, 8'h2b);
    rd(ADDR_C1_CTL0, 8'h29);
    cyc(1);
    chk(8'(convActive), 8'h00);
    chk(8'(muxConnect), 8'h01);
    wr(ADDR_C2_CTL0, 8'h0d);
    cyc(2);
    chk(8'(muxConnect), 8'h01);
    wr(ADDR_C2_CTL0, 8'h50);
    cyc(2);
    chk(8'(muxConnect), 8'h01);
    wr(ADDR_C2_CTL0, 8'h51);
    cyc(2);
    chk(8'(muxConnect), 8'h03);
    $display("test regs done");
  endtask : t_regs
  task automatic t_conv();
    level1 <= 10'h2c5;
    wr(ADDR_DSEN, 8'h01);
    wr(ADDR_C1_CTL0, 8'h2b);
    cyc(30);
    chk(8'(doneFlag), 8'h00);
    rd(ADDR_C1_CTL0, 8'h2b);
    waitc(2'b01, 100, 1'b1);
    rd(ADDR_C1_CTL0, 8'h29);
    rd(4'ha, 8'hb1);
    wr(ADDR_DSEN, 8'h00);
    level1 <= 10'h301;
    wr(ADDR_DONE, 8'h00);
    #1;
    chk(8'(doneFlag), 8'h00);
    wr(ADDR_C1_CTL0, 8'h2b);
    waitc(2'b01, 60, 1'b1);
    rd(ADDR_C1_CTL0, 8'h29);
    rd(4'h8, 8'hc0);
    rd(4'h9, 8'h40);
    rd(4'ha, 8'hb1);
    wr(ADDR_DONE, 8'h00);
    wr(ADDR_C1_CTL0, 8'h2b);
    cyc(10);
    wr(ADDR_C1_CTL0, 8'h29);
    cyc(2);
    chk(8'({convActive, doneFlag}), 8'h00);
    rd(4'h8, 8'hc0);
    rd(4'h9, 8'h00);
    // Half-rate conversion clock, right justified result
    wr(ADDR_SHARED, 8'hc0);
    wr(ADDR_C1_CTL0, 8'h2b);
    cyc(30);
    chk(8'(doneFlag), 8'h00);
    waitc(2'b01, 60, 1'b1);
    rd(4'h8, 8'h03);
    rd(4'h9, 8'h01);
    wr(ADDR_DONE, 8'h00);
    $display("test conversion done");
  endtask : t_conv
  task automatic t_sync();
    level2 <= 10'h155;
    wr(ADDR_SHARED, 8'h04);
    rd(ADDR_SHARED, 8'h04);
    chk(8'(convActive), 8'h03);
    waitc(2'b11, 60, 1'b1);
    rd(ADDR_SHARED, 8'h00);
    rd(4'hc, 8'h55);
    rd(4'hd, 8'h40);
    wr(ADDR_DONE, 8'h00);
    wr(ADDR_SHARED, 8'h04);
    cyc(6);
    wr(ADDR_SHARED, 8'h00);
    cyc(2);
    chk(8'({convActive, doneFlag}), 8'h00);
    $display("test sync done");
  endtask : t_sync
  task automatic t_trig();
    logic [2:0] codes [6] = '{TRG_TMR4, TRG_TMR0, TRG_TMR1, TRG_TMR2,
      TRG_PINR, TRG_PINF};
    foreach (codes[i]) begin
      wr(ADDR_DONE, 8'h00);
      wr(ADDR_C1_CTL2, {1'b0, codes[i], 4'h0});
      rd(ADDR_C1_CTL2, {1'b0, codes[i], 4'h0});
      @(posedge clk_sys);
      src(codes[i], 1'b1);
      @(posedge clk_sys);
      src(codes[i], 1'b0);
      waitc(2'b01, 4, 1'b0);
      waitc(2'b01, 60, 1'b1);
    end
    wr(ADDR_C1_CTL2, {1'b0, TRG_NONE, 4'h0});
    @(posedge clk_sys);
    tmr0Ovf <= 1'b1;
    @(posedge clk_sys);
    tmr0Ovf <= 1'b0;
    cyc(4);
    chk(8'(convActive), 8'h00);
    $display("test trigger done");
  endtask : t_trig
  task automatic t_sleep();
    wr(ADDR_DONE, 8'h00);
    wr(ADDR_C1_CTL0, 8'h2b);
    cyc(10);
    @(posedge clk_sys);
    sleepMode <= 1'b1;
    cyc(3);
    chk(8'({convActive[0], muxConnect[0], doneFlag}), 8'h00);
    rd(ADDR_C1_CTL0, 8'h01, 8'h01);
    @(posedge clk_sys);
    sleepMode <= 1'b0;
    wr(ADDR_SHARED, 8'h30);
    wr(ADDR_IE, 8'h01);
    @(posedge clk_sys);
    sleepMode <= 1'b1;
    wr(ADDR_C1_CTL0, 8'h2b);
    cyc(2);
    chk(8'(convActive), 8'h00);
    waitc(2'b01, 200, 1'b1);
    cyc(2);
    chk(8'(wakeReq), 8'h01);
    wr(ADDR_DONE, 8'h00);
    wr(ADDR_IE, 8'h00);
    wr(ADDR_C1_CTL0, 8'h2b);
    waitc(2'b01, 200, 1'b1);
    cyc(2);
    chk(8'({muxConnect[0], wakeReq}), 8'h00);
    rd(ADDR_C1_CTL0, 8'h01, 8'h01);
    @(posedge clk_sys);
    sleepMode <= 1'b0;
    wr(ADDR_SHARED, 8'h00);
    $display("test sleep done");
  endtask : t_sleep
  task automatic t_reset();
    wr(ADDR_C1_CTL0, 8'h2b);
    repeat (5) @(posedge clk_sys);
    rst_n <= 1'b0;
    cyc(2);
    chk(8'({convActive, doneFlag, muxConnect}), 8'h00);
    @(posedge clk_sys);
    rst_n <= 1'b1;
    rd(ADDR_C1_CTL0, CTL0_RST);
    rd(ADDR_SHARED, REG_RST);
    $display("test reset done");
  endtask : t_reset
  initial begin
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_regs();
    t_conv();
    t_sync();
    t_trig();
    t_sleep();
    t_reset();
    end_of_test();
  end
endmodule : dacc_top_test
bind dacc_top dacc_checker #(.INSTR_CYCLES(INSTR_CYCLES)) dacc_checker_inst (
  .clk_sys(clk_sys), .rst_n(rst_n), .regAddr(regAddr),
  .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb),
  .regRdData(regRdData), .sleepMode(sleepMode), .muxConnect(muxConnect),
  .muxCode(muxCode), .sarTrial(sarTrial), .convActive(convActive),
  .doneFlag(doneFlag), .wakeReq(wakeReq));

// ### verilog/dacc_top.sv
// Dual converter conversion sequencer with its register file
//
// The address-and-strobe port and the address map were chosen for this implementation.
`timescale 1ns/10ps
module dacc_top
  import dacc_pkg::*;
#(
  parameter int INSTR_CYCLES = 4
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Register port
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrStb,
  input wire logic regRdStb,
  output logic [7:0] regRdData,
  // System state and clocks
  input wire logic sleepMode,
  input wire logic rcHalfTick,
  // Trigger sources
  input wire logic tmr0Ovf,
  input wire logic tmr1Ovf,
  input wire logic tmr2Match,
  input wire logic tmr4Match,
  input wire logic extTrigPin,
  // Analog front end
  input wire logic [1:0] cmpHigh,
  output logic [1:0] muxConnect,
  output logic [11:0] muxCode,
  output logic [19:0] sarTrial,
  output logic [1:0] convActive,
  output logic [1:0] doneFlag,
  output logic wakeReq
);
  if (INSTR_CYCLES < 1 || INSTR_CYCLES > 255) begin : g_bad
    $error("INSTR_CYCLES out of range");
  end
  // ***************************************************************
  // Register decode
  // ***************************************************************
  wire logic [1:0] ctl0Wr;
  wire logic [1:0] ctl2Wr;
  wire logic sharedWr = regWrStb && regAddr == ADDR_SHARED;
  wire logic doneWr = regWrStb && regAddr == ADDR_DONE;
  wire logic dsenWr = regWrStb && regAddr == ADDR_DSEN;
  wire logic ieWr = regWrStb && regAddr == ADDR_IE;
  assign ctl0Wr[0] = regWrStb && regAddr == ADDR_C1_CTL0;
  assign ctl0Wr[1] = regWrStb && regAddr == ADDR_C2_CTL0;
  assign ctl2Wr[0] = regWrStb && regAddr == ADDR_C1_CTL2;
  assign ctl2Wr[1] = regWrStb && regAddr == ADDR_C2_CTL2;

  logic [7:0] shared_q;
  logic [1:0] dsen_q;
  logic [1:0] ie_q;
  logic sync_q;
  logic [5:0] divCnt_q;
  logic [4:0] srcPrev_q;
  logic [7:0] rdData_q;
  logic wake_q;

  wire logic [1:0] go;
  wire logic [1:0] done;
  wire logic [7:0] ctl0Rd [2];
  wire logic [7:0] ctl2Rd [2];
  wire logic [9:0] resW [2][2];

  // ***************************************************************
  // Shared control and conversion clock
  // ***************************************************************
  wire logic [2:0] clkSel = shared_q[CLK_HI:CLK_LO];
  wire logic frcSel = clkSel[1] & clkSel[0];
  wire logic [2:0] divShift = {clkSel[1], clkSel[0], clkSel[2]};
  wire logic [6:0] divMaskW = (7'h01 << divShift) - 7'h01;
  wire logic [5:0] divMask = divMaskW[5:0];
  wire logic divTick = (divCnt_q & divMask) == 6'h00;
  wire logic halfTick = frcSel ? rcHalfTick : divTick;
  // Setting sync go starts enabled converters only
  wire logic syncStart = sharedWr & regWrData[SYNC_BIT];
  wire logic syncAbort = sharedWr & ~regWrData[SYNC_BIT] & sync_q;

  // ***************************************************************
  // Trigger edges
  // ***************************************************************
  wire logic [4:0] srcNow = {extTrigPin, tmr4Match, tmr2Match, tmr1Ovf,
                             tmr0Ovf};
  wire logic [4:0] srcRise = srcNow & ~srcPrev_q;
  wire logic pinFall = ~extTrigPin & srcPrev_q[4];
  wire logic [7:0] trgEdge;
  // Source table indexed by trigger code
  assign trgEdge[TRG_NONE] = 1'b0;
  assign trgEdge[1] = 1'b0;
  assign trgEdge[TRG_TMR4] = srcRise[3];
  assign trgEdge[TRG_TMR0] = srcRise[0];
  assign trgEdge[TRG_TMR1] = srcRise[1];
  assign trgEdge[TRG_TMR2] = srcRise[2];
  assign trgEdge[TRG_PINR] = srcRise[4];
  assign trgEdge[TRG_PINF] = pinFall;

  // ***************************************************************
  // Channel decode
  // ***************************************************************
  function automatic logic chanValid(input logic conv, input logic [5:0] c);
    logic common;
    common = c == CH_FVR || c == CH_TEMP || c == CH_POSITIVE_CONV_REFERENCE || c <= CH_AN2;
    if (!conv) begin
      chanValid = common || (c >= CH_C1_LO && c <= CH_C1_HI);
    end else begin
      chanValid = common || (c >= CH_C2_LO && c <= CH_C2_HI) ||
                  (c >= CH_C2_X_LO && c <= CH_C2_X_HI);
    end
  endfunction : chanValid

  // Pads bits not yet decided with the last decided bit
  function automatic logic [9:0] fillPartial(input logic [9:0] sar,
                                             input logic [3:0] nDec);
    logic [9:0] r;
    logic last;
    r = sar;
    last = 1'b0;
    if (nDec != 4'd0) begin
      last = sar[4'd10 - nDec];
    end
    for (int j = 0; j < RES_W; j++) begin
      if (j < 32'(NDEC_FULL - nDec)) begin
        r[j] = last;
      end
    end
    fillPartial = r;
  endfunction : fillPartial

  // ***************************************************************
  // Per converter sequencer
  // ***************************************************************
  for (genvar i = 0; i < 2; i++) begin : g_conv
    logic [7:0] ctl0_q;
    logic [2:0] trg_q;
    logic go_q;
    logic off_q;
    logic flag_q;
    logic second_q;
    logic [7:0] wait_q;
    logic [4:0] half_q;
    logic [3:0] nDec_q;
    logic [9:0] sar_q;
    logic [9:0] res0_q;
    logic [9:0] res1_q;
    logic conn_q;
    dacc_state_t st_q;
    dacc_state_t st_d;

    wire logic en = ctl0_q[EN_BIT];
    wire logic enNext = ctl0Wr[i] ? regWrData[EN_BIT] : en;
    wire logic swSet = ctl0Wr[i] & regWrData[GO_BIT];
    wire logic swClr = ctl0Wr[i] & ~regWrData[GO_BIT] & go_q;
    wire logic trigHit = trgEdge[trg_q];
    // Start needs the enable already set
    wire logic startReq = en & enNext & ~go_q &
                          (swSet | syncStart | trigHit);
    wire logic abortSw = go_q & (swClr | syncAbort);
    wire logic sleepKill = sleepMode & ~frcSel;
    wire logic stop = ~enNext | abortSw | (sleepKill & go_q);
    wire logic [4:0] halfNext = half_q + 5'd1;
    wire logic decide = st_q == CS_CONV && halfTick && !halfNext[0] &&
                        halfNext >= HALF_FIRST && halfNext <= HALF_LAST;
    wire logic convEnd = st_q == CS_CONV && halfTick &&
                         halfNext == HALF_END && !stop;
    wire logic moreSample = convEnd & dsen_q[i] & ~second_q;
    wire logic finalEnd = convEnd & ~moreSample;
    wire logic partLoad = st_q == CS_CONV && abortSw;
    wire logic [3:0] bitIdx = 4'd9 - nDec_q;

    always_comb begin
      st_d = st_q;
      case (st_q)
        CS_IDLE: begin
          if (startReq) begin
            st_d = frcSel ? CS_WAIT : CS_CONV;
          end
        end
        CS_WAIT: begin
          if (stop) begin
            st_d = CS_IDLE;
          end else if (wait_q == 8'h00) begin
            st_d = CS_CONV;
          end
        end
        CS_CONV: begin
          if (stop || finalEnd) begin
            st_d = CS_IDLE;
          end
        end
        default: begin
          st_d = CS_IDLE;
        end
      endcase
    end

    // Reset clears every register of the converter
    always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
        st_q <= CS_IDLE;
        ctl0_q <= CTL0_RST;
        trg_q <= TRG_NONE;
        go_q <= 1'b0;
        wait_q <= 8'h00;
        half_q <= 5'h00;
        nDec_q <= 4'h0;
        sar_q <= 10'h000;
        second_q <= 1'b0;
      end else begin
        st_q <= st_d;
        if (ctl0Wr[i]) begin
          ctl0_q <= {regWrData[CHS_HI:CHS_LO], 1'b0, regWrData[EN_BIT]};
        end
        if (ctl2Wr[i]) begin
          trg_q <= regWrData[TRG_HI:TRG_LO];
        end
        // Go cleared at end, on abort or disable
        if (!enNext || stop || finalEnd) begin
          go_q <= 1'b0;
        end else if (startReq) begin
          go_q <= 1'b1;
        end
        if (st_q == CS_IDLE && startReq) begin
          wait_q <= 8'(INSTR_CYCLES - 1);
          second_q <= 1'b0;
        end else if (st_q == CS_WAIT) begin
          wait_q <= wait_q - 8'h01;
        end
        if (st_d == CS_CONV && st_q != CS_CONV) begin
          half_q <= 5'h00;
          nDec_q <= 4'h0;
          sar_q <= SAR_INIT;
        end else if (moreSample) begin
          half_q <= 5'h00;
          nDec_q <= 4'h0;
          sar_q <= SAR_INIT;
          second_q <= 1'b1;
        end else if (st_q == CS_CONV && halfTick) begin
          half_q <= halfNext;
          if (decide) begin
            sar_q[bitIdx] <= cmpHigh[i];
            if (bitIdx != 4'd0) begin
              sar_q[bitIdx - 4'd1] <= 1'b1;
            end
            nDec_q <= nDec_q + 4'd1;
          end
        end
      end
    end

    // Results, done flag, sleep power state and mux drive
    always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
        res0_q <= 10'h000;
        res1_q <= 10'h000;
        flag_q <= 1'b0;
        off_q <= 1'b0;
        conn_q <= 1'b0;
      end else begin
        // Set zero first, set one on the second sample
        if ((convEnd || partLoad) && !second_q) begin
          res0_q <= convEnd ? sar_q : fillPartial(sar_q, nDec_q);
        end
        if ((convEnd || partLoad) && second_q) begin
          res1_q <= convEnd ? sar_q : fillPartial(sar_q, nDec_q);
        end
        // Set wins over clear; abort never sets
        if (finalEnd) begin
          flag_q <= 1'b1;
        end else if (doneWr && !regWrData[i]) begin
          flag_q <= 1'b0;
        end
        if (!sleepMode) begin
          off_q <= 1'b0;
        end else if (sleepKill) begin
          off_q <= 1'b1;
        end else if (finalEnd && !ie_q[i]) begin
          off_q <= 1'b1;
        end
        // Disabled or powered down disconnects all inputs
        conn_q <= en & ~off_q & chanValid(i != 0, ctl0_q[CHS_HI:CHS_LO]);
      end
    end

    assign go[i] = go_q;
    assign done[i] = flag_q;
    assign ctl0Rd[i] = {ctl0_q[CHS_HI:CHS_LO], go_q, en};
    assign ctl2Rd[i] = {1'b0, trg_q, 4'h0};
    assign resW[i][0] = res0_q;
    assign resW[i][1] = res1_q;
    assign muxConnect[i] = conn_q;
    assign muxCode[i*6 +: 6] = ctl0_q[CHS_HI:CHS_LO];
    assign sarTrial[i*10 +: 10] = sar_q;
    assign convActive[i] = st_q == CS_CONV;
    assign doneFlag[i] = flag_q;
  end

  // ***************************************************************
  // Shared registers
  // ***************************************************************
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      shared_q <= REG_RST;
      dsen_q <= 2'b00;
      ie_q <= 2'b00;
      sync_q <= 1'b0;
      divCnt_q <= 6'h00;
      srcPrev_q <= 5'h00;
      wake_q <= 1'b0;
    end else begin
      if (sharedWr) begin
        shared_q <= regWrData & ~(8'h01 << SYNC_BIT);
      end
      if (dsenWr) begin
        dsen_q <= regWrData[1:0];
      end
      if (ieWr) begin
        ie_q <= regWrData[1:0];
      end
      // Sync flag follows the converters it started
      if (syncStart && (g_conv[0].en || g_conv[1].en)) begin
        sync_q <= 1'b1;
      end else if (syncAbort || go == 2'b00) begin
        sync_q <= 1'b0;
      end
      divCnt_q <= divCnt_q + 6'h01;
      srcPrev_q <= srcNow;
      wake_q <= sleepMode & |(done & ie_q);
    end
  end

  // ***************************************************************
  // Read path, data one cycle after the strobe
  // ***************************************************************
  wire logic [9:0] resSel = resW[regAddr[RES_CONV_BIT]][regAddr[RES_SET_BIT]];
  wire logic fmtRight = shared_q[FMT_BIT];
  wire logic [7:0] resHi = fmtRight ? {6'h00, resSel[9:8]} : resSel[9:2];
  wire logic [7:0] resLo = fmtRight ? resSel[7:0] : {resSel[1:0], 6'h00};
  wire logic [7:0] sharedRd = (shared_q & SHARED_KEEP & ~(8'h01 << SYNC_BIT)) |
                              (shared_q & 8'hf0) |
                              {5'h00, |go, 2'b00};
  logic [7:0] rdMux;
  always_comb begin
    rdMux = 8'h00;
    if (regAddr[RES_SEL_BIT]) begin
      rdMux = regAddr[RES_LO_BIT] ? resLo : resHi;
    end else begin
      case (regAddr)
        ADDR_C1_CTL0: rdMux = ctl0Rd[0];
        ADDR_C2_CTL0: rdMux = ctl0Rd[1];
        ADDR_SHARED: rdMux = sharedRd;
        ADDR_C1_CTL2: rdMux = ctl2Rd[0];
        ADDR_C2_CTL2: rdMux = ctl2Rd[1];
        ADDR_DONE: rdMux = {6'h00, done};
        ADDR_DSEN: rdMux = {6'h00, dsen_q};
        ADDR_IE: rdMux = {6'h00, ie_q};
        default: rdMux = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rdData_q <= 8'h00;
    end else begin
      rdData_q <= regRdStb ? rdMux : 8'h00;
    end
  end

  assign regRdData = rdData_q;
  assign wakeReq = wake_q;
endmodule : dacc_top
